// [hdl/rcs_regs.vh]
// Register map, field positions, reset values and codes of the
// reset-cause and clock-select block.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// Register byte offsets
`define RCS_ADDR_CAUSE     12'h000
`define RCS_ADDR_OSC       12'h004
`define RCS_ADDR_IRQ_STAT  12'h008
`define RCS_ADDR_IRQ_MASK  12'h00c
`define RCS_ADDR_MODE      12'h010

// Reset cause flag positions
`define RCS_BIT_POR        0
`define RCS_BIT_BROWN_OUT  1
`define RCS_BIT_CLEAR_PIN  2
`define RCS_BIT_SW_RESET   3
`define RCS_BIT_WATCHDOG   4
`define RCS_BIT_CFG_MISM   5
`define RCS_BIT_TRAP       6
`define RCS_BIT_ILLEGAL    7
`define RCS_CAUSE_W        8
`define RCS_CAUSE_RESET    8'h03

// Oscillator control fields
`define RCS_NEW_OSC_MSB    10
`define RCS_NEW_OSC_LSB    8
`define RCS_POSC_MSB       5
`define RCS_POSC_LSB       4
`define RCS_OSCIO_BIT      2
`define RCS_NEW_OSC_RESET  3'h7

// Oscillator selection codes
`define RCS_SEL_FAST_RC_DIV_N     3'h7
`define RCS_SEL_FAST_RC_DIV_16    3'h6
`define RCS_SEL_LOW_POWER_RC      3'h5
`define RCS_SEL_PRI_PLL           3'h3
`define RCS_SEL_PRI               3'h2
`define RCS_SEL_FAST_RC_DIV_N_PLL 3'h1
`define RCS_SEL_FAST_RC           3'h0

// Primary oscillator mode codes
`define RCS_POSC_HIGH_SPEED  2'h2
`define RCS_POSC_STANDARD    2'h1
`define RCS_POSC_EXTERNAL    2'h0

// Decoded clock modes
`define RCS_MODE_FAST_RC_DIV_N      4'h0
`define RCS_MODE_FAST_RC_DIV_16     4'h1
`define RCS_MODE_LOW_POWER_RC       4'h2
`define RCS_MODE_HI_SPEED_CRYSTAL_PLL 4'h3
`define RCS_MODE_STD_CRYSTAL_PLL    4'h4
`define RCS_MODE_EXT_CLOCK_PLL      4'h5
`define RCS_MODE_HI_SPEED_CRYSTAL   4'h6
`define RCS_MODE_STD_CRYSTAL        4'h7
`define RCS_MODE_EXT_CLOCK          4'h8
`define RCS_MODE_FAST_RC_DIV_N_PLL  4'h9
`define RCS_MODE_FAST_RC            4'ha

`endif

// [hdl/rcs_sync.v]
// Two-flop synchroniser for a bundle of slow levels.
// Assumes each bit is a quasi-static level from outside pclk.
`timescale 1ns/100ps
`default_nettype none
module rcs_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  reg [W-1:0] stage1_reg; // First stage, read only by stage two
  reg [W-1:0] stage2_reg; // Stable copy

  // Shift the level through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
    end else begin
      stage1_reg <= d_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign q_out = stage2_reg;
endmodule // rcs_sync
`default_nettype wire

// [hdl/rcs_rst_sync.v]
// Reset stretcher: asserts at once, releases on the clock.
// Assumes async_req is a glitch-tolerant OR of reset sources.
`timescale 1ns/100ps
`default_nettype none
module rcs_rst_sync (
  input  wire clk,
  input  wire async_req,
  output wire rst_out
);
  reg [1:0] chain_reg; // Release chain

  // Load ones while any source is active, shift zeros after
  always @(posedge clk or posedge async_req) begin
    if (async_req) begin
      chain_reg <= 2'b11;
    end else begin
      chain_reg <= {chain_reg[0], 1'b0};
    end
  end

  assign rst_out = chain_reg[1];
endmodule // rcs_rst_sync
`default_nettype wire

// [hdl/rcs_reset_clock_ctrl.v]
// Reset combiner, reset cause flags and initial clock selection,
// with an APB register slave and one level interrupt.
// Assumes presetn is the power-on reset and the fuse inputs are
// static levels; all other reset sources are active-high levels,
// except the reset instruction, a one-cycle pulse on pclk.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_regs.vh"

module rcs_reset_clock_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        brown_out_reset,
  input  wire        master_clear_pin_reset,
  input  wire        software_reset_instruction,
  input  wire        watchdog_timeout_reset,
  input  wire        config_mismatch_reset,
  input  wire        trap_conflict_reset,
  input  wire        illegal_condition_reset,
  input  wire [2:0]  initial_osc_select_cfg,
  input  wire [1:0]  primary_osc_mode_cfg,
  input  wire        osc_pin_io_function_cfg,
  output wire        master_system_reset,
  output wire [3:0]  clock_mode,
  output wire        clock_src_primary,
  output wire        clock_pll_enable,
  output wire        osc_out_pin_io,
  output wire        irq
);

  // True for codes that pick the primary oscillator
  function is_primary;
    input [2:0] sel;
    begin
      is_primary = (sel == `RCS_SEL_PRI) || (sel == `RCS_SEL_PRI_PLL);
    end
  endfunction

  // Map selection code and primary mode to one clock mode
  function [3:0] osc_decode;
    input [2:0] sel;
    input [1:0] posc;
    reg         pll;
    begin
      pll = (sel == `RCS_SEL_PRI_PLL);
      osc_decode = `RCS_MODE_FAST_RC_DIV_N;
      if (is_primary(sel)) begin
        // Mode field only matters for the primary source
        case (posc)
          `RCS_POSC_HIGH_SPEED: begin
            osc_decode = pll ? `RCS_MODE_HI_SPEED_CRYSTAL_PLL
                             : `RCS_MODE_HI_SPEED_CRYSTAL;
          end
          `RCS_POSC_STANDARD: begin
            osc_decode = pll ? `RCS_MODE_STD_CRYSTAL_PLL
                             : `RCS_MODE_STD_CRYSTAL;
          end
          default: begin
            // External clock, also for the unlisted code 11
            osc_decode = pll ? `RCS_MODE_EXT_CLOCK_PLL
                             : `RCS_MODE_EXT_CLOCK;
          end
        endcase
      end else begin
        case (sel)
          `RCS_SEL_FAST_RC_DIV_16: begin
            osc_decode = `RCS_MODE_FAST_RC_DIV_16;
          end
          `RCS_SEL_LOW_POWER_RC: begin
            osc_decode = `RCS_MODE_LOW_POWER_RC;
          end
          `RCS_SEL_FAST_RC_DIV_N_PLL: begin
            osc_decode = `RCS_MODE_FAST_RC_DIV_N_PLL;
          end
          `RCS_SEL_FAST_RC: begin
            osc_decode = `RCS_MODE_FAST_RC;
          end
          default: begin
            // 111 and the unlisted 100
            osc_decode = `RCS_MODE_FAST_RC_DIV_N;
          end
        endcase
      end
    end
  endfunction

  // Synchronised sources and fuses
  wire [5:0]  src_sync;          // Level sources after two flops
  wire [5:0]  cfg_sync;          // Fuse levels after two flops
  wire [2:0]  cfg_sel;           // Initial selection fuse
  wire [1:0]  cfg_posc;          // Primary mode fuse
  wire        cfg_oscio;         // Pin function fuse
  wire        any_src;           // Raw OR of every source
  wire [7:0]  hw_set;            // Flags raised this cycle

  // Bus decode
  wire        setup_rd;          // Read setup phase
  wire        acc_wr;            // Write access phase
  wire        hit;               // Address maps to a register
  wire        wr_cause;          // Write to cause flags
  wire        wr_osc;            // Write to oscillator control
  wire        wr_stat;           // Write to interrupt status
  wire        wr_mask;           // Write to interrupt mask

  // State
  reg         sw_reset_hold_reg; // Reset instruction held until seen
  reg  [7:0]  cause_reg;         // Reset cause flags
  reg  [7:0]  cause_next;
  reg  [7:0]  stat_reg;          // Sticky interrupt status
  reg  [7:0]  stat_next;
  reg  [7:0]  mask_reg;          // Interrupt mask
  reg  [2:0]  new_osc_reg;       // New-oscillator selection
  reg         reload_reg;        // Reset seen one edge ago
  reg  [3:0]  mode_reg;          // Decoded clock mode
  reg         primary_reg;       // Primary source in use
  reg         pll_reg;           // PLL in the path
  reg         oscio_reg;         // Pin function output
  reg  [31:0] prdata_reg;        // Read data
  reg  [31:0] rd_next;

  // Bring level sources into the clock domain
  rcs_sync #(
    .W (6)
  ) u_src_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d_in  ({illegal_condition_reset, trap_conflict_reset,
             config_mismatch_reset, watchdog_timeout_reset,
             master_clear_pin_reset, brown_out_reset}),
    .q_out (src_sync)
  );

  // Bring fuse levels into the clock domain
  rcs_sync #(
    .W (6)
  ) u_cfg_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d_in  ({osc_pin_io_function_cfg, primary_osc_mode_cfg,
             initial_osc_select_cfg}),
    .q_out (cfg_sync)
  );

  assign cfg_sel   = cfg_sync[2:0];
  assign cfg_posc  = cfg_sync[4:3];
  assign cfg_oscio = cfg_sync[5];

  // Any source, power-on included, requests the system reset
  assign any_src = ~presetn | brown_out_reset | master_clear_pin_reset |
                   watchdog_timeout_reset | config_mismatch_reset |
                   trap_conflict_reset | illegal_condition_reset |
                   sw_reset_hold_reg;

  // Immediate assertion, clocked release
  rcs_rst_sync u_rst_sync (
    .clk       (pclk),
    .async_req (any_src),
    .rst_out   (master_system_reset)
  );

  // Keep the reset instruction request until the reset is seen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reset_hold_reg <= 1'b0;
    end else if (software_reset_instruction) begin
      sw_reset_hold_reg <= 1'b1;
    end else if (master_system_reset) begin
      sw_reset_hold_reg <= 1'b0;
    end
  end

  // One flag per reset kind; power-on is the async reset value
  assign hw_set = {src_sync[5:2], software_reset_instruction,
                   src_sync[1:0], 1'b0};

  // APB decode, zero wait states
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr   = psel & penable & pwrite;
  assign hit      = (paddr == `RCS_ADDR_CAUSE) ||
                    (paddr == `RCS_ADDR_OSC) ||
                    (paddr == `RCS_ADDR_IRQ_STAT) ||
                    (paddr == `RCS_ADDR_IRQ_MASK) ||
                    (paddr == `RCS_ADDR_MODE);
  assign wr_cause = acc_wr & (paddr == `RCS_ADDR_CAUSE);
  assign wr_osc   = acc_wr & (paddr == `RCS_ADDR_OSC);
  assign wr_stat  = acc_wr & (paddr == `RCS_ADDR_IRQ_STAT);
  assign wr_mask  = acc_wr & (paddr == `RCS_ADDR_IRQ_MASK);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;

  // Next flag and status values; hardware set wins over a clear
  always @* begin
    if (wr_cause) begin
      // Plain store, no reset request is raised from here
      cause_next = pwdata[7:0] | hw_set;
    end else begin
      cause_next = cause_reg | hw_set;
    end
    stat_next = stat_reg;
    if (wr_stat) begin
      // Write one to clear
      stat_next = stat_reg & ~pwdata[7:0];
    end
    // A flag set by hardware while clear is an event
    stat_next = stat_next | (hw_set & ~cause_reg);
  end

  // Flags, status and mask survive every reset but power-on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= `RCS_CAUSE_RESET;
      stat_reg  <= 8'h00;
      mask_reg  <= 8'h00;
    end else begin
      cause_reg <= cause_next;
      stat_reg  <= stat_next;
      if (wr_mask) begin
        mask_reg <= pwdata[7:0];
      end
    end
  end

  // One extra fuse load after release: after power-on the fuse copy
  // only settles on the edge that ends the reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= 1'b1;
    end else begin
      reload_reg <= master_system_reset;
    end
  end

  // New-oscillator field: fuse copy on every reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_osc_reg <= `RCS_NEW_OSC_RESET;
    end else if (master_system_reset || reload_reg) begin
      new_osc_reg <= cfg_sel;
    end else if (wr_osc) begin
      new_osc_reg <= pwdata[`RCS_NEW_OSC_MSB:`RCS_NEW_OSC_LSB];
    end
  end

  // Mode, source and PLL outputs follow the selection; pin function follows its fuse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg    <= `RCS_MODE_FAST_RC_DIV_N;
      primary_reg <= 1'b0;
      pll_reg     <= 1'b0;
      oscio_reg   <= 1'b0;
    end else begin
      mode_reg    <= osc_decode(new_osc_reg, cfg_posc);
      primary_reg <= is_primary(new_osc_reg);
      pll_reg     <= (new_osc_reg == `RCS_SEL_PRI_PLL) ||
                     (new_osc_reg == `RCS_SEL_FAST_RC_DIV_N_PLL);
      oscio_reg   <= cfg_oscio;
    end
  end

  // Read mux; unmapped reads as zero
  always @* begin
    rd_next = 32'h0000_0000;
    if (paddr == `RCS_ADDR_CAUSE) begin
      rd_next = {24'h00_0000, cause_reg};
    end else if (paddr == `RCS_ADDR_OSC) begin
      rd_next = {21'h00_0000, new_osc_reg, 2'h0, cfg_posc,
                 1'b0, cfg_oscio, 2'h0};
    end else if (paddr == `RCS_ADDR_IRQ_STAT) begin
      rd_next = {24'h00_0000, stat_reg};
    end else if (paddr == `RCS_ADDR_IRQ_MASK) begin
      rd_next = {24'h00_0000, mask_reg};
    end else if (paddr == `RCS_ADDR_MODE) begin
      rd_next = {28'h000_0000, mode_reg};
    end
  end

  // Capture read data in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_reg <= rd_next;
    end
  end

  // Outputs
  assign prdata            = prdata_reg;
  assign clock_mode        = mode_reg;
  assign clock_src_primary = primary_reg;
  assign clock_pll_enable  = pll_reg;
  assign osc_out_pin_io    = oscio_reg;
  assign irq               = |(stat_reg & mask_reg);

endmodule // rcs_reset_clock_ctrl
`default_nettype wire

// [sim/rcs_src_model.sv]
// Far-side model: reset sources and configuration fuses.
// Assumes the bench calls its tasks just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module rcs_src_model (
  input  wire logic       pclk,
  output var  logic [6:0] src,
  output var  logic [2:0] sel,
  output var  logic [1:0] posc,
  output var  logic       oscio
);
  // Erased fuses: fast RC with divide-by-N, pin as I/O
  initial begin
    src   = 7'h00;
    sel   = 3'h7;
    posc  = 2'h0;
    oscio = 1'b1;
  end

  // Raise source k; the reset instruction is a one-cycle pulse
  task automatic fire(input int k, input int h);
    src[k] <= 1'b1;
    repeat ((k == 2) ? 1 : h) @(posedge pclk);
    src[k] <= 1'b0;
  endtask

  // New fuse levels; pin function set in the same step as the selection
  task automatic set_fuse(input logic [2:0] s, input logic [1:0] p, input logic o);
    sel   <= s;
    posc  <= p;
    oscio <= o;
  endtask
endmodule // rcs_src_model
`default_nettype wire

// [sim/rcs_chk.sv]
// Port-level assertions for the reset-cause and clock-select block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module rcs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        brown_out_reset,
  input wire logic        master_clear_pin_reset,
  input wire logic        software_reset_instruction,
  input wire logic        watchdog_timeout_reset,
  input wire logic        config_mismatch_reset,
  input wire logic        trap_conflict_reset,
  input wire logic        illegal_condition_reset,
  input wire logic [2:0]  initial_osc_select_cfg,
  input wire logic        osc_pin_io_function_cfg,
  input wire logic        master_system_reset,
  input wire logic [3:0]  clock_mode,
  input wire logic        clock_src_primary,
  input wire logic        clock_pll_enable,
  input wire logic        osc_out_pin_io
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any level source of reset
  wire logic lvl = brown_out_reset | master_clear_pin_reset | watchdog_timeout_reset
                 | config_mismatch_reset | trap_conflict_reset | illegal_condition_reset;
  wire logic sw_rst = software_reset_instruction;
  wire logic msr = master_system_reset;

  property p_lvl; lvl |-> msr; endproperty
  a_lvl: assert property (p_lvl) else $error("level source without reset");
  property p_sw_rst; sw_rst |=> msr; endproperty
  a_sw_rst: assert property (p_sw_rst) else $error("reset instruction ignored");
  property p_fall; $fell(msr) |-> !lvl && !$past(lvl); endproperty
  a_fall: assert property (p_fall) else $error("reset released early");
  // The instruction pulse holds the request one edge longer
  property p_rel; !$past(sw_rst) ##0 (!lvl && !sw_rst) [*3] |-> !msr; endproperty
  a_rel: assert property (p_rel) else $error("reset held too long");
  property p_pri; clock_src_primary == (clock_mode >= 4'h3 && clock_mode <= 4'h8); endproperty
  a_pri: assert property (p_pri) else $error("primary flag wrong");
  property p_pll; clock_pll_enable == (clock_mode inside {4'h3, 4'h4, 4'h5, 4'h9}); endproperty
  a_pll: assert property (p_pll) else $error("pll flag wrong");
  property p_fuse;
    $fell(msr) |-> ##[1:3] (clock_src_primary == (initial_osc_select_cfg[2:1] == 2'b01)
      && clock_pll_enable == (initial_osc_select_cfg inside {3'h1, 3'h3}));
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse not loaded");
  property p_oscio;
    $stable(osc_pin_io_function_cfg) [*5] |-> osc_out_pin_io == osc_pin_io_function_cfg;
  endproperty
  a_oscio: assert property (p_oscio) else $error("pin function wrong");
  property p_err;
    psel && penable |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010});
  endproperty
  a_err: assert property (p_err) else $error("bus error wrong");
  property p_norst; psel && penable && !lvl && !sw_rst && !msr |=> !msr; endproperty
  a_norst: assert property (p_norst) else $error("access caused reset");
  c_sw_rst: cover property (sw_rst ##1 msr);
  c_fell: cover property ($fell(msr));
  c_err: cover property (pslverr);
endmodule // rcs_chk
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the reset-cause and clock-select block.
// Assumes the design, its header and the source model are compiled.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_regs.vh"
module tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  wire  logic [31:0] prdata;
  wire  logic pready, pslverr, master_system_reset, clock_src_primary, clock_pll_enable;
  wire  logic osc_out_pin_io, irq, brown_out_reset, master_clear_pin_reset;
  wire  logic software_reset_instruction, watchdog_timeout_reset, config_mismatch_reset;
  wire  logic trap_conflict_reset, illegal_condition_reset, osc_pin_io_function_cfg;
  wire  logic [3:0] clock_mode;
  wire  logic [2:0] initial_osc_select_cfg;
  wire  logic [1:0] primary_osc_mode_cfg;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          k;
  logic [31:0] rd;
  logic [31:0] er;
  logic [7:0]  exp_cause;
  logic [7:0]  mask;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  rcs_src_model MDL (.pclk, .sel(initial_osc_select_cfg), .posc(primary_osc_mode_cfg),
    .oscio(osc_pin_io_function_cfg), .src({illegal_condition_reset, trap_conflict_reset,
    config_mismatch_reset, watchdog_timeout_reset, software_reset_instruction,
    master_clear_pin_reset, brown_out_reset}));
  rcs_reset_clock_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .brown_out_reset, .master_clear_pin_reset,
    .software_reset_instruction, .watchdog_timeout_reset, .config_mismatch_reset,
    .trap_conflict_reset, .illegal_condition_reset, .initial_osc_select_cfg,
    .primary_osc_mode_cfg, .osc_pin_io_function_cfg, .master_system_reset, .clock_mode,
    .clock_src_primary, .clock_pll_enable, .osc_out_pin_io, .irq);

  // Count and report one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, one idle cycle after
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Read and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Wait for the system reset to release, bounded
  task automatic wait_rel();
    for (int n = 0; n < 100 && master_system_reset !== 1'b0; n++) @(posedge pclk);
    chk({31'h0, master_system_reset}, 32'h0);
  endtask

  // Expected clock mode from fuse selection and primary mode
  function automatic logic [3:0] dec(input logic [2:0] s, input logic [1:0] p);
    case (s)
      3'h7, 3'h4: dec = 4'h0;
      3'h6: dec = 4'h1;
      3'h5: dec = 4'h2;
      3'h3: dec = (p == 2'h2) ? 4'h3 : (p == 2'h1) ? 4'h4 : 4'h5;
      3'h2: dec = (p == 2'h2) ? 4'h6 : (p == 2'h1) ? 4'h7 : 4'h8;
      3'h1: dec = 4'h9;
      default: dec = 4'ha;
    endcase
  endfunction

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Main sequence
  initial begin
    k = $urandom(69274);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_rel();
    rdc(`RCS_ADDR_CAUSE, 32'h3);
    rdc(`RCS_ADDR_MODE, 32'h0);
    rdc(12'h014, 32'h0);
    chk(er, 32'h1);
    apb(1'b1, `RCS_ADDR_CAUSE, 32'hff);
    chk({31'h0, master_system_reset}, 32'h0);
    rdc(`RCS_ADDR_CAUSE, 32'hff);
    apb(1'b1, `RCS_ADDR_CAUSE, 32'h0);
    rdc(`RCS_ADDR_CAUSE, 32'h0);
    apb(1'b1, `RCS_ADDR_OSC, 32'h0000_0200);
    rdc(`RCS_ADDR_OSC, {21'h0, 3'h2, 2'h0, primary_osc_mode_cfg, 1'b0,
      osc_pin_io_function_cfg, 2'h0});
    rdc(`RCS_ADDR_MODE, {28'h0, dec(3'h2, primary_osc_mode_cfg)});
    $display("Test flags done");
    // Every source, every selection code
    for (int i = 0; i < 8; i++) begin
      mask = 8'($urandom);
      apb(1'b1, `RCS_ADDR_IRQ_MASK, {24'h0, mask});
      MDL.set_fuse(3'(i), 2'($urandom), 1'($urandom));
      repeat (4) @(posedge pclk);
      MDL.fire(i % 7, 3 + $urandom % 6);
      wait_rel();
      exp_cause = 8'h1 << (i % 7 + 1);
      rdc(`RCS_ADDR_CAUSE, {24'h0, exp_cause});
      chk({31'h0, irq}, {31'h0, |(exp_cause & mask)});
      rdc(`RCS_ADDR_IRQ_STAT, {24'h0, exp_cause});
      rdc(`RCS_ADDR_OSC, {21'h0, initial_osc_select_cfg, 2'h0, primary_osc_mode_cfg,
        1'b0, osc_pin_io_function_cfg, 2'h0});
      rdc(`RCS_ADDR_MODE, {28'h0, dec(initial_osc_select_cfg, primary_osc_mode_cfg)});
      apb(1'b1, `RCS_ADDR_IRQ_STAT, {24'h0, exp_cause});
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `RCS_ADDR_CAUSE, 32'h0);
      $display("Test source %0d done", i);
    end
    // Second power-on in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_rel();
    rdc(`RCS_ADDR_CAUSE, 32'h3);
    rdc(`RCS_ADDR_IRQ_MASK, 32'h0);
    rdc(`RCS_ADDR_MODE, {28'h0, dec(initial_osc_select_cfg, primary_osc_mode_cfg)});
    $display("Test power-on done");
    end_of_test();
  end
endmodule // tb

bind rcs_reset_clock_ctrl rcs_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .brown_out_reset, .master_clear_pin_reset, .software_reset_instruction,
  .watchdog_timeout_reset, .config_mismatch_reset, .trap_conflict_reset,
  .illegal_condition_reset, .initial_osc_select_cfg, .osc_pin_io_function_cfg,
  .master_system_reset, .clock_mode, .clock_src_primary, .clock_pll_enable,
  .osc_out_pin_io);
`default_nettype wire
